/* hw/ssp_regs.svh */
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH
// word geometry
`define SSP_WORD_W 24
`define SSP_ADDR_HI 23
`define SSP_ADDR_LO 22
`define SSP_TEST_BIT 21
// address codes
`define SSP_ADDR_A 2'h0
`define SSP_ADDR_B 2'h1
`define SSP_ADDR_D 3'h6
// main divider word fields
`define SSP_A_MODSEL 21
`define SSP_A_NF_HI 20
`define SSP_A_NF_LO 18
`define SSP_A_N_HI 17
`define SSP_A_N_LO 2
// reference control word fields
`define SSP_B_R_HI 21
`define SSP_B_R_LO 12
`define SSP_B_LOCKSEL 11
`define SSP_B_PWR 10
`define SSP_B_CP 9
`define SSP_B_FC_HI 8
`define SSP_B_FC_LO 1
// test word field
`define SSP_D_SPU 15
// reset values
`define SSP_RST_MODSEL 1'h0
`define SSP_RST_NF 3'h2
`define SSP_RST_N 16'h2230
`define SSP_RST_R 10'h051
`define SSP_RST_LOCKSEL 1'h0
`define SSP_RST_PWR 1'h0
`define SSP_RST_CP 1'h0
`define SSP_RST_FC 8'h50
`define SSP_RST_SPU 1'h0
// accumulator modulo
`define SSP_MOD_FIVE 4'h5
`define SSP_MOD_EIGHT 4'h8
`endif

/* hw/ssp_pkg.sv */
`default_nettype none
package ssp_pkg;
    // load sequencer states, one-hot
    typedef enum logic [2:0] {
        SSP_IDLE = 3'h1,
        SSP_LOAD = 3'h2,
        SSP_HOLD = 3'h4
    } ssp_state_t;
    // destination of a shifted word
    typedef enum logic [1:0] {
        SSP_KIND_A = 2'h0,
        SSP_KIND_B = 2'h1,
        SSP_KIND_D = 2'h2,
        SSP_KIND_NONE = 2'h3
    } ssp_kind_t;
endpackage : ssp_pkg
`default_nettype wire

/* hw/ssp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two-stage level synchroniser, one per bit
module ssp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stageOne; // read only by the second stage

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            // both stages cleared by reset
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    stageOne[i] <= 1'h0;
                    dout[i] <= 1'h0;
                end else begin
                    stageOne[i] <= din[i];
                    dout[i] <= stageOne[i];
                end
            end
        end
    endgenerate
endmodule : ssp_sync
`default_nettype wire

/* hw/ssp_shift.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssp_regs.svh"
// link-side shift register on the serial clock
module ssp_shift
    import ssp_pkg::*;
(
    input wire logic serClk,
    input wire logic resetn,
    input wire logic serStrobe,
    input wire logic serData,
    output logic [`SSP_WORD_W-1:0] shiftWord
);
    // right shift: first bit ends at bit 0, last at bit 23
    always_ff @(posedge serClk or negedge resetn) begin
        if (!resetn) begin
            shiftWord <= '0;
        end else if (!serStrobe) begin
            shiftWord <= {serData, shiftWord[`SSP_WORD_W-1:1]};
        end
        // strobe high: clock ignored, contents frozen
    end

    a_shift_frozen: assert property (@(posedge serClk) disable iff (!resetn)
        serStrobe |=> $stable(shiftWord))
        else $error("shift register moved while strobe high");

    a_shift_sample: assert property (@(posedge serClk) disable iff (!resetn)
        !serStrobe |=> shiftWord[`SSP_WORD_W-1] == $past(serData))
        else $error("serial data not taken at rising edge");
endmodule : ssp_shift
`default_nettype wire

/* hw/ssp_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssp_regs.svh"
module ssp_top
    import ssp_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic serClk,
    input wire logic serStrobe,
    input wire logic serData,
    input wire logic hwPowerPin,
    input wire logic mainLockDet,
    output logic fracModulusSel,
    output logic [3:0] fracModulo,
    output logic [2:0] fracIncrement,
    output logic [15:0] mainRatio,
    output logic [9:0] refRatio,
    output logic lockOutSel,
    output logic softPowerBit,
    output logic pumpRatioSel,
    output logic [7:0] compDac,
    output logic mainPowerOn,
    output logic pumpSpeedUp,
    output logic testSpeedUp,
    output logic lockPinOut,
    output logic lockPinOeN
);
    // classify a word by its leading address bits
    function automatic ssp_kind_t word_kind(input logic [`SSP_WORD_W-1:0] w);
        ssp_kind_t k;
        k = SSP_KIND_NONE;
        if (w[`SSP_ADDR_HI:`SSP_ADDR_LO] == `SSP_ADDR_A) begin
            k = SSP_KIND_A;
        end else if (w[`SSP_ADDR_HI:`SSP_ADDR_LO] == `SSP_ADDR_B) begin
            k = SSP_KIND_B;
        end else if (w[`SSP_ADDR_HI:`SSP_TEST_BIT] == `SSP_ADDR_D) begin
            k = SSP_KIND_D;
        end
        return k;
    endfunction : word_kind

    // link-domain shift register
    logic [`SSP_WORD_W-1:0] shiftWord; // frozen while strobe high

    ssp_shift u_shift (
        .serClk(serClk),
        .resetn(resetn),
        .serStrobe(serStrobe),
        .serData(serData),
        .shiftWord(shiftWord)
    );

    // pins into the core domain
    logic [2:0] pinSync; // strobe, power pin, lock detect
    logic strobeSync; // synchronised strobe
    logic hwPowerSync; // synchronised power pin
    logic lockSync; // synchronised lock detect

    ssp_sync #(.WIDTH(3)) u_sync (
        .clk(core_clk),
        .resetn(resetn),
        .din({serStrobe, hwPowerPin, mainLockDet}),
        .dout(pinSync)
    );

    assign strobeSync = pinSync[2];
    assign hwPowerSync = pinSync[1];
    assign lockSync = pinSync[0];

    // strobe edge detection on the synchronised level
    logic strobeLast; // previous synchronised strobe
    logic strobeRise; // one-cycle pulse

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            strobeLast <= 1'h0;
        end else begin
            strobeLast <= strobeSync;
        end
    end

    assign strobeRise = strobeSync & ~strobeLast;

    // load sequencer
    ssp_state_t state; // current state
    ssp_state_t next_state; // next state

    // next-state decode
    always_comb begin
        next_state = state;
        unique case (state)
            SSP_IDLE: begin
                // wait for the strobe to arrive
                if (strobeRise) begin
                    next_state = SSP_LOAD;
                end
            end
            SSP_LOAD: begin
                // one cycle of loading
                next_state = SSP_HOLD;
            end
            SSP_HOLD: begin
                // one load per strobe pulse
                if (!strobeSync) begin
                    next_state = SSP_IDLE;
                end
            end
            default: begin
                // illegal code: recover to idle
                next_state = SSP_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= SSP_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // word capture across the domain boundary
    // the shift word is static while strobe is high, so the
    // synchronised strobe qualifies it; no bit can be mid-change
    logic [`SSP_WORD_W-1:0] wordHold; // captured word

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wordHold <= '0;
        end else if (strobeRise) begin
            wordHold <= shiftWord;
        end
    end

    // decoded load strobes
    ssp_kind_t holdKind; // kind of captured word
    logic loadA; // main divider word load
    logic loadB; // reference control word load
    logic loadD; // test word load

    assign holdKind = word_kind(wordHold);
    assign loadA = (state == SSP_LOAD) && (holdKind == SSP_KIND_A);
    assign loadB = (state == SSP_LOAD) && (holdKind == SSP_KIND_B);
    assign loadD = (state == SSP_LOAD) && (holdKind == SSP_KIND_D);

    // main divider word registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fracModulusSel <= `SSP_RST_MODSEL;
            fracIncrement <= `SSP_RST_NF;
            mainRatio <= `SSP_RST_N;
        end else if (loadA) begin
            fracModulusSel <= wordHold[`SSP_A_MODSEL];
            fracIncrement <= wordHold[`SSP_A_NF_HI:`SSP_A_NF_LO];
            mainRatio <= wordHold[`SSP_A_N_HI:`SSP_A_N_LO];
        end
    end

    // accumulator modulo from the select bit
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fracModulo <= `SSP_MOD_EIGHT;
        end else begin
            fracModulo <= fracModulusSel ? `SSP_MOD_FIVE : `SSP_MOD_EIGHT;
        end
    end

    // reference control word registers
    logic [7:0] dacTemp; // staged DAC code

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            refRatio <= `SSP_RST_R;
            lockOutSel <= `SSP_RST_LOCKSEL;
            softPowerBit <= `SSP_RST_PWR;
            pumpRatioSel <= `SSP_RST_CP;
            dacTemp <= `SSP_RST_FC;
        end else if (loadB) begin
            refRatio <= wordHold[`SSP_B_R_HI:`SSP_B_R_LO];
            lockOutSel <= wordHold[`SSP_B_LOCKSEL];
            softPowerBit <= wordHold[`SSP_B_PWR];
            pumpRatioSel <= wordHold[`SSP_B_CP];
            dacTemp <= wordHold[`SSP_B_FC_HI:`SSP_B_FC_LO];
        end
    end

    // working DAC code moves only with the main ratio
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            compDac <= `SSP_RST_FC;
        end else if (loadA) begin
            compDac <= dacTemp;
        end
    end

    // test word: speed-up force bit
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            testSpeedUp <= `SSP_RST_SPU;
        end else if (loadD) begin
            testSpeedUp <= wordHold[`SSP_D_SPU];
        end
    end

    // pumps speed up from an A load until strobe falls
    logic aStrobeHeld; // A word loaded, strobe still high

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            aStrobeHeld <= 1'h0;
        end else if (loadA) begin
            aStrobeHeld <= 1'h1;
        end else if (!strobeSync) begin
            aStrobeHeld <= 1'h0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pumpSpeedUp <= 1'h0;
        end else begin
            pumpSpeedUp <= testSpeedUp | aStrobeHeld;
        end
    end

    // effective power: the pin inverts the software bit
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mainPowerOn <= 1'h0;
        end else begin
            mainPowerOn <= softPowerBit ^ hwPowerSync;
        end
    end

    // lock pin: 0 push-pull, 1 open drain
    // powered-down dividers report out of lock
    logic lockValid; // lock qualified by power

    assign lockValid = lockSync & mainPowerOn;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lockPinOut <= 1'h0;
            lockPinOeN <= 1'h0;
        end else if (lockOutSel) begin
            // pull low when unlocked, release when locked
            lockPinOut <= 1'h0;
            lockPinOeN <= lockValid;
        end else begin
            // drive the level both ways
            lockPinOut <= lockValid;
            lockPinOeN <= 1'h0;
        end
    end

    // checks
    a_load_follows: assert property (@(posedge core_clk) disable iff (!resetn)
        strobeRise |=> state == SSP_LOAD ##1 state == SSP_HOLD)
        else $error("strobe rise did not start a load");

    a_dac_staged: assert property (@(posedge core_clk) disable iff (!resetn)
        loadB |=> $stable(compDac) && dacTemp == $past(wordHold[`SSP_B_FC_HI:`SSP_B_FC_LO]))
        else $error("DAC code moved on B load");

    a_dac_moves: assert property (@(posedge core_clk) disable iff (!resetn)
        loadA |=> compDac == $past(dacTemp) && mainRatio == $past(wordHold[`SSP_A_N_HI:`SSP_A_N_LO]))
        else $error("DAC code not moved with main ratio");

    a_a_fields: assert property (@(posedge core_clk) disable iff (!resetn)
        loadA |=> fracIncrement == $past(wordHold[`SSP_A_NF_HI:`SSP_A_NF_LO])
            && fracModulusSel == $past(wordHold[`SSP_A_MODSEL]))
        else $error("A word fields wrong");

    a_b_fields: assert property (@(posedge core_clk) disable iff (!resetn)
        loadB |=> refRatio == $past(wordHold[`SSP_B_R_HI:`SSP_B_R_LO])
            && pumpRatioSel == $past(wordHold[`SSP_B_CP]))
        else $error("B word fields wrong");

    a_test_ignored: assert property (@(posedge core_clk) disable iff (!resetn)
        (state == SSP_LOAD && wordHold[`SSP_ADDR_HI]) |=> $stable(mainRatio) && $stable(refRatio))
        else $error("test word reached working registers");

    a_modulo_map: assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(fracModulusSel) |=> fracModulo == `SSP_MOD_FIVE)
        else $error("modulo not five");

    // the other direction: a broken map to five only would slip past the check above
    a_modulo_eight: assert property (@(posedge core_clk) disable iff (!resetn)
        $fell(fracModulusSel) |=> fracModulo == `SSP_MOD_EIGHT)
        else $error("modulo not eight");

    a_power_xor: assert property (@(posedge core_clk) disable iff (!resetn)
        ##1 mainPowerOn == ($past(softPowerBit) ^ $past(hwPowerSync)))
        else $error("power state not pin xor bit");

    // power and lock select bits land from their own positions
    a_power_bit: assert property (@(posedge core_clk) disable iff (!resetn)
        loadB |=> softPowerBit == $past(wordHold[`SSP_B_PWR])
            && lockOutSel == $past(wordHold[`SSP_B_LOCKSEL]))
        else $error("power or lock select bit wrong");

    // test word speed-up bit taken from its field
    a_test_bit: assert property (@(posedge core_clk) disable iff (!resetn)
        loadD |=> testSpeedUp == $past(wordHold[`SSP_D_SPU]))
        else $error("test speed-up bit wrong");

    // forced speed-up must reach the pumps one cycle later
    a_test_force: assert property (@(posedge core_clk) disable iff (!resetn)
        testSpeedUp |=> pumpSpeedUp)
        else $error("forced speed-up not applied");

    // open drain never drives high; it releases while locked
    a_lock_drain: assert property (@(posedge core_clk) disable iff (!resetn)
        lockOutSel |=> !lockPinOut && lockPinOeN == $past(lockValid))
        else $error("open-drain lock pin misdriven");

    // push-pull keeps the pin driven and follows the lock level
    a_lock_push: assert property (@(posedge core_clk) disable iff (!resetn)
        !lockOutSel |=> lockPinOut == $past(lockValid) && !lockPinOeN)
        else $error("push-pull lock pin misdriven");

    c_a_load: cover property (@(posedge core_clk) disable iff (!resetn) loadA);
    c_b_then_a: cover property (@(posedge core_clk) disable iff (!resetn)
        loadB ##[1:200] loadA);
    c_test_load: cover property (@(posedge core_clk) disable iff (!resetn) loadD);
    c_speed_up: cover property (@(posedge core_clk) disable iff (!resetn) $rose(pumpSpeedUp));
endmodule : ssp_top
`default_nettype wire

/* bench/ssp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// host controller on the three-wire programming link
module ssp_host_model (
    output logic serClk,
    output logic serStrobe,
    output logic serData
);
    // link idles with clock low and strobe low
    initial begin
        serClk = 1'h0;
        serStrobe = 1'h0;
        serData = 1'h0;
    end
    // shifts nBits of w, p0 first, then strobes; extra clocks during strobe
    task automatic send_word(input logic [23:0] w, input int nBits, input int extra);
        int i;
        #100; // strobe low spacing before a new frame
        for (i = 0; i < nBits; i++) begin
            serData = w[i];
            #40 serClk = 1'h1;
            #40 serClk = 1'h0; // data moves only at the falling edge
        end
        // no hold owed past the frame, so the stale bit is not left
        serData = ~serData;
        #40 serStrobe = 1'h1;
        // clocks here must be ignored by the device
        for (i = 0; i < extra; i++) begin
            #40 serClk = 1'h1;
            serData = ~serData;
            #40 serClk = 1'h0;
        end
        #640 serStrobe = 1'h0; // well over four core cycles high
        #100;
    endtask : send_word
endmodule : ssp_host_model
`default_nettype wire

/* bench/ssp_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// one compare, counted, reported at once on mismatch
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin nFail++; \
    $display("mismatch at %0t got %h exp %h", $time, (a), (e)); end end
module ssp_top_tb;
    logic core_clk, resetn, hwPowerPin, mainLockDet; // bench-driven inputs
    logic serClk, serStrobe, serData; // driven by the host model
    logic fracModulusSel, lockOutSel, softPowerBit, pumpRatioSel;
    logic mainPowerOn, pumpSpeedUp, testSpeedUp, lockPinOut, lockPinOeN;
    logic [3:0] fracModulo;
    logic [2:0] fracIncrement;
    logic [15:0] mainRatio;
    logic [9:0] refRatio;
    logic [7:0] compDac;
    int nFail, numChecks, i, k, p;
    ssp_host_model host (.serClk(serClk), .serStrobe(serStrobe), .serData(serData));
    ssp_top dut (.core_clk(core_clk), .resetn(resetn), .serClk(serClk), .serStrobe(serStrobe),
        .serData(serData), .hwPowerPin(hwPowerPin), .mainLockDet(mainLockDet),
        .fracModulusSel(fracModulusSel), .fracModulo(fracModulo), .fracIncrement(fracIncrement),
        .mainRatio(mainRatio), .refRatio(refRatio), .lockOutSel(lockOutSel),
        .softPowerBit(softPowerBit), .pumpRatioSel(pumpRatioSel), .compDac(compDac),
        .mainPowerOn(mainPowerOn), .pumpSpeedUp(pumpSpeedUp), .testSpeedUp(testSpeedUp),
        .lockPinOut(lockPinOut), .lockPinOeN(lockPinOeN));
    // 20 MHz core clock
    initial begin
        core_clk = 1'h0;
        forever #25 core_clk = ~core_clk;
    end
    // main divider word image
    function automatic logic [23:0] a_word(logic modSel, logic [2:0] inc, logic [15:0] n);
        return {2'h0, modSel, inc, n, 2'h0};
    endfunction : a_word
    // reference control word image
    function automatic logic [23:0] b_word(logic [9:0] r, logic lockSel, logic pwrBit, logic cp, logic [7:0] dac);
        return {2'h1, r, lockSel, pwrBit, cp, dac, 1'h0};
    endfunction : b_word
    // core cycles, landing on falling edges
    task automatic wait_n(input int n);
        repeat (n) @(negedge core_clk);
    endtask : wait_n
    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask : end_test
    // verdict and end of run
    task automatic finish_test;
        $display("checks %0d mismatches %0d", numChecks, nFail);
        if (nFail == 0 && numChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    // cuts a hang short; tests need well under this
    initial begin
        #400000;
        nFail++;
        $display("mismatch at %0t watchdog expired", $time);
        finish_test();
    end
    // test sequence
    initial begin
        nFail = 0;
        numChecks = 0;
        resetn = 1'h0;
        hwPowerPin = 1'h0;
        mainLockDet = 1'h0;
        wait_n(10);
        resetn = 1'h1;
        wait_n(5);
        // defaults after reset
        `CHK(fracModulusSel, 1'h0)
        `CHK(fracIncrement, 3'h2)
        `CHK(mainRatio, 16'h2230)
        `CHK(refRatio, 10'h051)
        `CHK({lockOutSel, softPowerBit, pumpRatioSel}, 3'h0)
        `CHK(compDac, 8'h50)
        `CHK(fracModulo, 4'h8)
        `CHK({testSpeedUp, pumpSpeedUp, mainPowerOn}, 3'h0)
        end_test("defaults");
        // B first, DAC code staged only
        host.send_word(b_word(10'h3FF, 1'h1, 1'h1, 1'h1, 8'hA5), 24, 0);
        `CHK(refRatio, 10'h3FF)
        `CHK({lockOutSel, softPowerBit}, 2'h3)
        `CHK(pumpRatioSel, 1'h1)
        `CHK(compDac, 8'h50)
        // every increment code, both moduli, speed-up while strobe high
        for (i = 0; i < 8; i++) begin
            fork
                host.send_word(a_word(i[0], i[2:0], 16'h0200 + 16'(i)), 24, 0);
                begin
                    @(posedge serStrobe);
                    wait_n(7);
                    `CHK(pumpSpeedUp, 1'h1)
                end
            join
            wait_n(4);
            `CHK(fracIncrement, i[2:0])
            `CHK(mainRatio, 16'h0200 + 16'(i))
            `CHK(fracModulusSel, i[0])
            `CHK(fracModulo, i[0] ? 4'h5 : 4'h8)
            `CHK(compDac, 8'hA5)
            `CHK(pumpSpeedUp, 1'h0)
        end
        end_test("frac");
        // DAC extremes, power bit against pin
        for (k = 0; k < 2; k++) begin
            host.send_word(b_word(10'h004, 1'h0, k[0], 1'h0, k[0] ? 8'hFF : 8'h00), 24, 0);
            `CHK(compDac, k[0] ? 8'h00 : 8'hA5)
            host.send_word(a_word(1'h0, 3'h0, 16'hFFFF), 24, 0);
            `CHK(compDac, k[0] ? 8'hFF : 8'h00)
            for (p = 0; p < 2; p++) begin
                hwPowerPin = p[0];
                wait_n(6);
                `CHK(mainPowerOn, k[0] ^ p[0])
            end
            hwPowerPin = 1'h0;
        end
        end_test("power");
        // lock pin drive for both select codes, powered
        for (k = 0; k < 2; k++) begin
            host.send_word(b_word(10'h051, k[0], 1'h1, 1'h0, 8'h50), 24, 0);
            for (p = 0; p < 2; p++) begin
                mainLockDet = p[0];
                wait_n(6);
                `CHK(lockPinOut, k[0] ? 1'h0 : p[0])
                `CHK(lockPinOeN, k[0] ? p[0] : 1'h0)
            end
        end
        // powered down reads out of lock
        host.send_word(b_word(10'h051, 1'h0, 1'h0, 1'h0, 8'h50), 24, 0);
        wait_n(6);
        `CHK(lockPinOut, 1'h0)
        mainLockDet = 1'h0;
        end_test("lock");
        // clocks during strobe must not disturb the shifted word
        host.send_word(a_word(1'h1, 3'h5, 16'h1234), 24, 4);
        `CHK(mainRatio, 16'h1234)
        host.send_word(24'h000000, 0, 0);
        `CHK(mainRatio, 16'h1234)
        `CHK(fracIncrement, 3'h5)
        // address 111 goes nowhere
        host.send_word(24'hFFFFFF, 24, 0);
        `CHK(mainRatio, 16'h1234)
        `CHK(refRatio, 10'h051)
        // test word speed-up on, then off
        host.send_word({3'h6, 5'h00, 1'h1, 15'h0000}, 24, 0);
        wait_n(4);
        `CHK({testSpeedUp, pumpSpeedUp}, 2'h3)
        `CHK(mainRatio, 16'h1234)
        host.send_word({3'h6, 21'h000000}, 24, 0);
        wait_n(4);
        `CHK({testSpeedUp, pumpSpeedUp}, 2'h0)
        end_test("decode");
        finish_test();
    end
endmodule : ssp_top_tb
`default_nettype wire
